// ==== rtl/l2lf_arbiter.sv ====
// l2 miss linefill path with read arbitration toward next-level memory
// Contract
// (R01) storage is in 32-byte lines and every allocation, lookup and eviction uses that size.
// (R02) by default a miss fetches one line as four 64-bit read beats.
// (R03) the double-line fetch is enabled by bit 30 of the prefetch configuration word.
// (R04) with double fetch enabled a miss fetches 64 bytes as eight 64-bit beats over two lines.
// (R05) during a double fetch the second line is looked up and a victim is chosen on a miss.
// (R06) a dirty victim is evicted first and the second line is not allocated before that ends.
// (R07) double fetch is disabled after reset until software sets the enable bit.
// (R08) auxiliary bit 10, reset low, puts strongly-ordered and device reads ahead of fills.
// (R09) the master interface has four outstanding address slots shared by all reads.
// (R10) a normal-memory read matching an active store on address bits 31:5 waits for it.
// (R11) eviction requests use a level request held until acknowledged, so none is lost.
// (R12) with priority on, a pending fill is still issued under a continuous uncached flow.
`timescale 1ns/10ps
module l2lf_arbiter
  import l2lf_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration words
  input wire logic [31:0] prefetch_cfg_i,
  input wire logic [31:0] aux_cfg_i,
  // cacheable miss requests
  input wire logic miss_valid_i,
  output logic miss_ready_o,
  input wire logic [l2lf_pkg::ADDR_W-1:0] miss_addr_i,
  // uncached reads
  input wire logic unc_valid_i,
  output logic unc_ready_o,
  input wire logic [l2lf_pkg::ADDR_W-1:0] unc_addr_i,
  input wire logic unc_normal_i,
  // active store buffer write
  input wire logic sb_active_i,
  input wire logic [l2lf_pkg::ADDR_W-1:0] sb_addr_i,
  // next-level read address
  output logic ar_valid_o,
  input wire logic ar_ready_i,
  output logic [l2lf_pkg::ADDR_W-1:0] ar_addr_o,
  output logic [3:0] ar_len_o,
  output logic ar_fill_o,
  // next-level read data
  input wire logic r_valid_i,
  output logic r_ready_o,
  input wire logic [l2lf_pkg::BEAT_W-1:0] r_data_i,
  input wire logic r_last_i,
  input wire logic r_fill_i,
  // returned beats toward the cache side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [l2lf_pkg::BEAT_W-1:0] rd_data_o,
  output logic rd_last_o,
  // second line lookup
  output logic lk_valid_o,
  output logic [l2lf_pkg::ADDR_W-1:0] lk_addr_o,
  input wire logic lk_done_i,
  input wire logic lk_hit_i,
  input wire logic lk_dirty_i,
  // victim eviction
  output logic ev_req_o,
  input wire logic ev_ack_i,
  // line allocation
  output logic alloc1_o,
  output logic alloc2_o,
  output logic [l2lf_pkg::ADDR_W-1:0] alloc_addr_o
);
  import l2lf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  l2lf_state_t st_reg, st_next;
  logic dbl_en_reg, dbl_en_next, hp_en_reg, hp_en_next;
  logic [ADDR_W-1:0] miss_addr_reg, miss_addr_next;
  logic miss_dbl_reg, miss_dbl_next;
  logic [3:0] beat_reg, beat_next;
  logic data_done_reg, data_done_next;
  logic lk_pend_reg, lk_pend_next;
  logic ev_req_reg, ev_req_next;
  logic alloc2_need_reg, alloc2_need_next;
  logic [2:0] slots_reg, slots_next;
  logic [2:0] starve_reg, starve_next;
  logic fill_req, unc_req, slot_free, grant_fill, grant_unc, ar_fire;
  logic r_fire, r_done, miss_haz, unc_haz, finish, fill_beat;
  logic [3:0] beats_total;

  // ----------------------------------------------------------------
  // hazard check and arbitration
  // ----------------------------------------------------------------
  assign miss_haz = sb_active_i && (miss_addr_i[ADDR_W-1:LINE_LSB] ==
    sb_addr_i[ADDR_W-1:LINE_LSB]); // [R10]
  assign unc_haz = unc_normal_i && sb_active_i &&
    (unc_addr_i[ADDR_W-1:LINE_LSB] == sb_addr_i[ADDR_W-1:LINE_LSB]); // [R10]
  assign fill_req = (st_reg == ST_ISSUE);
  assign unc_req = unc_valid_i && !unc_haz;
  assign slot_free = (slots_reg < NUM_SLOTS); // [R09]
  // without priority, a waiting fill goes first; with it, uncached first until starved
  assign grant_fill = fill_req && slot_free &&
    (!unc_req || !hp_en_reg || (starve_reg >= STARVE_LIMIT)); // [R08] [R12]
  assign grant_unc = unc_req && slot_free && !grant_fill; // [R08]
  assign ar_valid_o = grant_fill || grant_unc;
  assign ar_fire = ar_valid_o && ar_ready_i;
  assign ar_fill_o = grant_fill;
  assign ar_addr_o = grant_fill ? miss_addr_reg : unc_addr_i;
  assign ar_len_o = grant_fill ? (miss_dbl_reg ? DOUBLE_LEN : SINGLE_LEN) : 4'h0; // [R02] [R04]
  assign unc_ready_o = grant_unc && ar_ready_i;
  assign miss_ready_o = (st_reg == ST_IDLE) && !miss_haz; // [R10]

  // ----------------------------------------------------------------
  // returned data and allocation
  // ----------------------------------------------------------------
  assign r_fire = r_valid_i && r_ready_o;
  assign r_done = r_fire && r_last_i;
  assign fill_beat = r_fire && r_fill_i && (st_reg == ST_FILL);
  assign beats_total = miss_dbl_reg ? DOUBLE_BEATS : SINGLE_BEATS;
  assign alloc1_o = fill_beat && (beat_reg == SINGLE_BEATS - 4'h1); // [R01] [R02]
  // second line waits for data, lookup and any dirty writeback
  assign finish = (st_reg == ST_FILL) && data_done_reg && !lk_pend_reg && !ev_req_reg; // [R06]
  assign alloc2_o = finish && alloc2_need_reg; // [R06]
  assign alloc_addr_o = alloc2_o ? (miss_addr_reg + 32'(LINE_BYTES)) : miss_addr_reg; // [R01]
  assign lk_valid_o = lk_pend_reg; // [R05]
  assign lk_addr_o = miss_addr_reg + 32'(LINE_BYTES); // [R05]
  assign ev_req_o = ev_req_reg; // [R11]

  always_comb begin
    st_next = st_reg;
    dbl_en_next = prefetch_cfg_i[DBL_FILL_BIT]; // [R03]
    hp_en_next = aux_cfg_i[HP_READ_BIT]; // [R08]
    miss_addr_next = miss_addr_reg;
    miss_dbl_next = miss_dbl_reg;
    beat_next = beat_reg;
    data_done_next = data_done_reg;
    lk_pend_next = lk_pend_reg;
    ev_req_next = ev_req_reg;
    alloc2_need_next = alloc2_need_reg;
    slots_next = slots_reg;
    starve_next = starve_reg;
    if (ar_fire && !r_done) begin
      slots_next = slots_reg + 3'h1; // [R09]
    end else if (r_done && !ar_fire) begin
      slots_next = slots_reg - 3'h1;
    end
    if (grant_fill && ar_ready_i) begin
      starve_next = 3'h0; // [R12]
    end else if (fill_req && grant_unc && ar_ready_i && starve_reg < STARVE_LIMIT) begin
      starve_next = starve_reg + 3'h1; // [R12]
    end
    case (st_reg)
      ST_IDLE: begin
        if (miss_valid_i && miss_ready_o) begin
          // requests are line aligned; the double fetch covers an aligned pair
          miss_dbl_next = dbl_en_reg; // [R04]
          miss_addr_next = dbl_en_reg ? {miss_addr_i[ADDR_W-1:LINE_LSB+1], 6'h00}
            : {miss_addr_i[ADDR_W-1:LINE_LSB], 5'h00}; // [R01]
          st_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (grant_fill && ar_ready_i) begin
          beat_next = 4'h0;
          data_done_next = 1'b0;
          lk_pend_next = miss_dbl_reg; // [R05]
          alloc2_need_next = 1'b0;
          st_next = ST_FILL;
        end
      end
      ST_FILL: begin
        if (fill_beat) begin
          beat_next = beat_reg + 4'h1;
          if (beat_reg == beats_total - 4'h1) begin
            data_done_next = 1'b1; // [R04]
          end
        end
        if (lk_pend_reg && lk_done_i) begin
          lk_pend_next = 1'b0;
          alloc2_need_next = !lk_hit_i; // [R05]
          ev_req_next = !lk_hit_i && lk_dirty_i; // [R06]
        end else if (ev_req_reg && ev_ack_i) begin
          ev_req_next = 1'b0; // [R11]
        end
        if (finish) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_IDLE;
      dbl_en_reg <= DBL_FILL_RST; // [R07]
      hp_en_reg <= HP_READ_RST; // [R08]
      miss_addr_reg <= '0;
      miss_dbl_reg <= 1'b0;
      beat_reg <= 4'h0;
      data_done_reg <= 1'b0;
      lk_pend_reg <= 1'b0;
      ev_req_reg <= 1'b0;
      alloc2_need_reg <= 1'b0;
      slots_reg <= 3'h0;
      starve_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      dbl_en_reg <= dbl_en_next;
      hp_en_reg <= hp_en_next;
      miss_addr_reg <= miss_addr_next;
      miss_dbl_reg <= miss_dbl_next;
      beat_reg <= beat_next;
      data_done_reg <= data_done_next;
      lk_pend_reg <= lk_pend_next;
      ev_req_reg <= ev_req_next;
      alloc2_need_reg <= alloc2_need_next;
      slots_reg <= slots_next;
      starve_reg <= starve_next;
    end
  end

  // ----------------------------------------------------------------
  // beat buffer; a stalled cache side stops accepting read data
  // ----------------------------------------------------------------
  l2lf_fifo #(.WIDTH(BEAT_W + 1), .DEPTH(FIFO_DEPTH)) u_beat_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(r_valid_i),
    .in_ready_o(r_ready_o),
    .in_data_i({r_last_i, r_data_i}),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o({rd_last_o, rd_data_o})
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  line_align_a: assert property (alloc1_o |-> alloc_addr_o[4:0] == 5'h00) // [R01]
    else $error("allocated line not aligned");
  single_len_a: assert property (grant_fill && !miss_dbl_reg |-> ar_len_o == 4'h3) // [R02]
    else $error("single fill length wrong");
  dbl_cfg_a: assert property ((st_reg == ST_IDLE) && miss_valid_i && miss_ready_o // [R03]
    && dbl_en_reg |=> miss_dbl_reg)
    else $error("double fill enable not honoured");
  dbl_len_a: assert property (grant_fill && miss_dbl_reg |-> ar_len_o == 4'h7) // [R04]
    else $error("double fill length wrong");
  lookup_start_a: assert property (grant_fill && ar_ready_i && miss_dbl_reg // [R05]
    |=> lk_valid_o && lk_addr_o == miss_addr_reg + 32'h20)
    else $error("second line lookup missing");
  evict_first_a: assert property (alloc2_o |-> !ev_req_o && !lk_valid_o) // [R06]
    else $error("second line allocated before eviction");
  rst_dbl_off_a: assert property ($rose(rst_n_i) |-> !dbl_en_reg) // [R07]
    else $error("double fill on after reset");
  so_first_a: assert property (hp_en_reg && unc_req && fill_req && slot_free // [R08]
    && starve_reg < STARVE_LIMIT |-> grant_unc)
    else $error("uncached read not prioritised");
  slot_cap_a: assert property (slots_reg == NUM_SLOTS |-> !ar_valid_o) // [R09]
    else $error("fifth address slot issued");
  hazard_hold_a: assert property (miss_haz |-> !miss_ready_o) // [R10]
    else $error("read passed a matching store");
  ev_hold_a: assert property (ev_req_o && !ev_ack_i |=> ev_req_o) // [R11]
    else $error("eviction request dropped");
  no_starve_a: assert property (fill_req && slot_free && starve_reg == STARVE_LIMIT // [R12]
    |-> grant_fill)
    else $error("fill starved by uncached flow");
endmodule

// ==== rtl/l2lf_fifo.sv ====
// synchronous valid/ready fifo for returned read beats
`timescale 1ns/10ps
module l2lf_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule

// ==== rtl/l2lf_pkg.sv ====
// shared constants for the l2 linefill and read arbiter
package l2lf_pkg;
  // ----------------------------------------------------------------
  // line and burst geometry
  // ----------------------------------------------------------------
  localparam int LINE_BYTES = 32;
  localparam int LINE_LSB = 5;
  localparam int BEAT_W = 64;
  localparam int ADDR_W = 32;
  localparam logic [3:0] SINGLE_BEATS = 4'h4;
  localparam logic [3:0] DOUBLE_BEATS = 4'h8;
  localparam logic [3:0] SINGLE_LEN = 4'h3;
  localparam logic [3:0] DOUBLE_LEN = 4'h7;
  // ----------------------------------------------------------------
  // configuration bit positions and reset values
  // ----------------------------------------------------------------
  localparam int DBL_FILL_BIT = 30;
  localparam int HP_READ_BIT = 10;
  localparam logic DBL_FILL_RST = 1'b0;
  localparam logic HP_READ_RST = 1'b0;
  // ----------------------------------------------------------------
  // master interface slots and fairness
  // ----------------------------------------------------------------
  localparam logic [2:0] NUM_SLOTS = 3'h4;
  localparam logic [2:0] STARVE_LIMIT = 3'h4;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FILL} l2lf_state_t;
endpackage

// ==== tb/l2lf_mem_model.sv ====
// behavioural next-level memory that answers read bursts
`timescale 1ns/10ps
module l2lf_mem_model
  import l2lf_pkg::*;
(
  // clock, reset and stall
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hold_i,
  // read address
  input wire logic ar_valid_i,
  output logic ar_ready_o,
  input wire logic [l2lf_pkg::ADDR_W-1:0] ar_addr_i,
  input wire logic [3:0] ar_len_i,
  input wire logic ar_fill_i,
  // read data
  output logic r_valid_o,
  input wire logic r_ready_i,
  output logic [l2lf_pkg::BEAT_W-1:0] r_data_o,
  output logic r_last_o,
  output logic r_fill_o
);
  logic [36:0] pend_q[$];
  int beat;
  // always takes addresses: the slot limit is the arbiter's job
  assign ar_ready_o = 1'b1;
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pend_q.delete();
      beat = 0;
      r_valid_o <= 1'b0;
      r_last_o <= 1'b0;
      r_fill_o <= 1'b0;
      r_data_o <= 64'h5a5a_5a5a_5a5a_5a5a;
    end else begin
      if (ar_valid_i) pend_q.push_back({ar_fill_i, ar_len_i, ar_addr_i});
      if (r_valid_o && r_ready_i) begin
        beat = r_last_o ? 0 : beat + 1;
        if (r_last_o) void'(pend_q.pop_front());
      end
      // an offered beat stays put until taken
      if (!(r_valid_o && !r_ready_i)) begin
        if (pend_q.size() > 0 && !hold_i) begin
          r_valid_o <= 1'b1;
          r_data_o <= {32'h0, pend_q[0][31:0]} + 64'(beat);
          r_last_o <= (beat == int'(pend_q[0][35:32]));
          r_fill_o <= pend_q[0][36];
        end else begin
          // idle bus shows a changing pattern on data, last and fill, with valid low
          r_valid_o <= 1'b0;
          r_data_o <= ~r_data_o;
          r_last_o <= ~r_last_o;
          r_fill_o <= ~r_fill_o;
        end
      end
    end
  end
endmodule

// ==== tb/tb_l2lf_arbiter.sv ====
// self-checking bench for the linefill and read arbiter
`timescale 1ns/10ps
module tb_l2lf_arbiter;
  import l2lf_pkg::*;
  logic clk = 1'b0;
  logic rst_n, hold, mv, mr, uv, ur, unorm, sba, arv, arr, arfill, rv, rr, rlast, rfill;
  logic dv, drdy, dlast, lkv, lkd, lkh, lkdy, evq, eva, a1, a2;
  logic [31:0] pcfg, acfg, maddr, uaddr, sbaddr, araddr, lkaddr, aaddr;
  logic [3:0] arlen;
  logic [63:0] rdata, ddata;
  logic [64:0] rd_q[$];
  logic [36:0] ar_q[$];
  logic [31:0] a1_q[$], a2_q[$];
  int mismatches = 0, cmp_count = 0, out_cnt = 0, racc = 0, ev_cnt = 0;
  always #2.5 clk = ~clk;
  l2lf_arbiter i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .prefetch_cfg_i(pcfg),
    .aux_cfg_i(acfg), .miss_valid_i(mv), .miss_ready_o(mr), .miss_addr_i(maddr),
    .unc_valid_i(uv), .unc_ready_o(ur), .unc_addr_i(uaddr), .unc_normal_i(unorm),
    .sb_active_i(sba), .sb_addr_i(sbaddr), .ar_valid_o(arv), .ar_ready_i(arr),
    .ar_addr_o(araddr), .ar_len_o(arlen), .ar_fill_o(arfill), .r_valid_i(rv),
    .r_ready_o(rr), .r_data_i(rdata), .r_last_i(rlast), .r_fill_i(rfill),
    .rd_valid_o(dv), .rd_ready_i(drdy), .rd_data_o(ddata), .rd_last_o(dlast),
    .lk_valid_o(lkv), .lk_addr_o(lkaddr), .lk_done_i(lkd), .lk_hit_i(lkh),
    .lk_dirty_i(lkdy), .ev_req_o(evq), .ev_ack_i(eva), .alloc1_o(a1), .alloc2_o(a2),
    .alloc_addr_o(aaddr));
  l2lf_mem_model i_mem (.core_clk_i(clk), .rst_n_i(rst_n), .hold_i(hold),
    .ar_valid_i(arv), .ar_ready_o(arr), .ar_addr_i(araddr), .ar_len_i(arlen),
    .ar_fill_i(arfill), .r_valid_o(rv), .r_ready_i(rr), .r_data_o(rdata),
    .r_last_o(rlast), .r_fill_o(rfill));
  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst_n) begin
      if (dv && drdy) rd_q.push_back({dlast, ddata});
      if (arv && arr) ar_q.push_back({arfill, arlen, araddr});
      out_cnt = out_cnt + int'(arv && arr) - int'(rv && rr && rlast);
      if (rv && rr) racc++;
      if (a1) a1_q.push_back(aaddr);
      if (a2) a2_q.push_back(aaddr);
      if (evq) ev_cnt++;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 300) begin
      mismatches++;
      $display("BAD wait expected done seen timeout");
      print_verdict();
    end
  endtask
  task automatic clr();
    rd_q.delete();
    ar_q.delete();
    a1_q.delete();
    a2_q.delete();
    racc = 0;
    ev_cnt = 0;
  endtask
  task automatic do_miss(input logic [31:0] a);
    int n;
    maddr = a;
    mv = 1'b1;
    for (n = 0; n < 300 && mr !== 1'b1; n++) @(negedge clk);
    tmo(n);
    @(negedge clk);
    mv = 1'b0;
  endtask
  task automatic chk_beats(input logic [31:0] a, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      chk("beat data", {32'h0, a} + 64'(i), rd_q[i][63:0]);
      chk("beat last", 64'(i == cnt - 1), 64'(rd_q[i][64]));
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_single();
    int n;
    clr();
    do_miss(32'h1000_0040);
    for (n = 0; n < 300 && rd_q.size() < 4; n++) @(negedge clk);
    tmo(n);
    chk("fill issue", {27'h0, 1'b1, SINGLE_LEN, 32'h1000_0040}, {27'h0, ar_q[0]});
    chk_beats(32'h1000_0040, 4);
    chk("first alloc", 64'h1000_0040, {32'h0, a1_q[0]});
  endtask
  task automatic t_double();
    int n;
    pcfg = 32'h4000_0000;
    drdy = 1'b0;
    @(negedge clk);
    clr();
    do_miss(32'h2000_0080);
    for (n = 0; n < 300 && lkv !== 1'b1; n++) @(negedge clk);
    tmo(n);
    chk("lookup addr", 64'h2000_00a0, {32'h0, lkaddr});
    {lkd, lkh, lkdy} = 3'b101;
    @(negedge clk);
    lkd = 1'b0;
    // data side stalled: the fifo takes all eight beats, then refuses
    for (n = 0; n < 300 && racc < 8; n++) @(negedge clk);
    tmo(n);
    repeat (3) @(negedge clk);
    chk("double len", {60'h0, DOUBLE_LEN}, {60'h0, ar_q[0][35:32]});
    chk("fifo full", 64'h0, {63'h0, rr});
    chk("evict req", 64'h1, {63'h0, evq});
    chk("early alloc", 64'h0, 64'(a2_q.size()));
    eva = 1'b1;
    @(negedge clk);
    eva = 1'b0;
    for (n = 0; n < 300 && a2_q.size() < 1; n++) @(negedge clk);
    tmo(n);
    chk("second alloc", 64'h2000_00a0, {32'h0, a2_q[0]});
    chk("evict done", 64'h0, {63'h0, evq});
    drdy = 1'b1;
    for (n = 0; n < 300 && rd_q.size() < 8; n++) @(negedge clk);
    tmo(n);
    chk_beats(32'h2000_0080, 8);
    chk("fifo empty", 64'h0, {63'h0, dv});
    pcfg = 32'h0;
  endtask
  // a clean victim or a hit on the second line must not cause a writeback
  task automatic t_dbl_lk(input logic hit);
    int n;
    pcfg = 32'h4000_0000;
    @(negedge clk);
    clr();
    do_miss(32'h6000_0060);
    for (n = 0; n < 300 && lkv !== 1'b1; n++) @(negedge clk);
    tmo(n);
    chk("lookup addr", 64'h6000_0060, {32'h0, lkaddr});
    {lkd, lkh, lkdy} = {1'b1, hit, 1'b0};
    @(negedge clk);
    lkd = 1'b0;
    for (n = 0; n < 300 && (mr !== 1'b1 || rd_q.size() < 8); n++) @(negedge clk);
    tmo(n);
    chk("double issue", {27'h0, 1'b1, DOUBLE_LEN, 32'h6000_0040}, {27'h0, ar_q[0]});
    chk_beats(32'h6000_0040, 8);
    chk("first alloc", 64'h6000_0040, {32'h0, a1_q[0]});
    chk("clean evict", 64'h0, 64'(ev_cnt));
    chk("second allocs", 64'(!hit), 64'(a2_q.size()));
    if (!hit) chk("second addr", 64'h6000_0060, {32'h0, a2_q[0]});
    pcfg = 32'h0;
  endtask
  task automatic t_hazard();
    int n;
    clr();
    {sba, sbaddr, maddr, uaddr, unorm, uv} = {1'b1, 32'h3000_011f, 32'h3000_0100,
      32'h3000_0100, 1'b1, 1'b1};
    @(negedge clk);
    chk("miss held", 64'h0, {63'h0, mr});
    chk("read held", 64'h0, {63'h0, ur});
    unorm = 1'b0;
    #1;
    chk("device read", 64'h1, {63'h0, ur});
    @(negedge clk);
    uv = 1'b0;
    sbaddr = 32'h3000_0120;
    #1;
    chk("other line", 64'h1, {63'h0, mr});
    @(negedge clk);
    sba = 1'b0;
    for (n = 0; n < 300 && rd_q.size() < 1; n++) @(negedge clk);
    tmo(n);
    chk("read issue", {32'h0, 32'h3000_0100}, {27'h0, ar_q[0]});
  endtask
  task automatic t_prio();
    int n, beats;
    acfg = 32'h0000_0400;
    hold = 1'b1;
    uaddr = 32'h4000_0000;
    @(negedge clk);
    clr();
    do_miss(32'h5000_0000);
    uv = 1'b1;
    for (n = 0; n < 300 && out_cnt < 4; n++) @(negedge clk);
    tmo(n);
    repeat (2) @(negedge clk);
    chk("reads first", 64'h0, {63'h0, ar_q[0][36] | ar_q[3][36]});
    chk("slots", 64'h4, 64'(ar_q.size()));
    chk("slot refuse", 64'h0, {63'h0, ur});
    hold = 1'b0;
    for (n = 0; n < 300 && ar_q.size() < 5; n++) @(negedge clk);
    tmo(n);
    chk("fill wins", {59'h0, 1'b1, SINGLE_LEN}, {59'h0, ar_q[4][36:32]});
    for (n = 0; n < 300 && ur !== 1'b1; n++) @(negedge clk);
    tmo(n);
    @(negedge clk);
    uv = 1'b0;
    for (n = 0; n < 300 && (out_cnt != 0 || dv !== 1'b0); n++) @(negedge clk);
    tmo(n);
    beats = 0;
    foreach (ar_q[i]) beats += int'(ar_q[i][35:32]) + 1;
    chk("beats back", 64'(beats), 64'(rd_q.size()));
    acfg = 32'h0;
  endtask
  initial begin
    {rst_n, hold, mv, uv, unorm, sba, lkd, lkh, lkdy, eva} = '0;
    {pcfg, acfg, maddr, uaddr, sbaddr} = '0;
    drdy = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_single();
    t_double();
    t_dbl_lk(1'b0);
    t_dbl_lk(1'b1);
    t_hazard();
    t_prio();
    print_verdict();
  end
endmodule
